// ### design/lat_delay_if.sv
// interface: one delay timer's control and result
`timescale 1ns/10ps
`default_nettype none
interface lat_delay_if;
  logic        enable;
  logic [13:0] preset;
  logic        out;
  modport ctrl  (output enable, output preset, input out);
  modport timer (input enable, input preset, output out);
endinterface
`default_nettype wire

// ### design/lat_delay_timer.sv
// module: delay timer usable as on-delay or off-delay
`timescale 1ns/10ps
`default_nettype none
module lat_delay_timer #(
  parameter bit OFF_DELAY = 1'b0
) (
  // clock and reset
  input  wire logic   core_clk,
  input  wire logic   rst,
  input  wire logic   sync_clr,
  // timing strobes
  input  wire logic   scan_en,
  input  wire logic   tick,
  // control and result
  lat_delay_if.timer  dly
);
  logic [13:0] count_reg;
  logic [13:0] count_next;
  logic        out_reg;
  logic        out_next;
  logic        tick_seen_reg;
  logic        tick_seen_next;
  logic        run;
  logic [13:0] preset_sat;

  assign dly.out = out_reg;

  always_comb begin
    count_next     = count_reg;
    out_next       = out_reg;
    tick_seen_next = tick_seen_reg | tick;
    preset_sat     = (dly.preset > lat_pkg::PRESET_MAX) ? lat_pkg::PRESET_MAX : dly.preset;
    // timing runs while the input sits in the delaying state
    run = OFF_DELAY ? ~dly.enable : dly.enable;
    if (scan_en) begin
      // this scan uses any pending tick; keeping it would count it twice
      tick_seen_next = 1'b0;
      if (!run) begin
        // delaying state left: clear elapsed time
        count_next = lat_pkg::COUNT_RST;
        out_next   = OFF_DELAY;
      end else begin
        // one tick between scans is caught; a second tick before the next scan is lost
        if ((tick_seen_reg | tick) && count_reg < preset_sat) begin
          count_next = count_reg + 14'h0001;
        end
        if (count_next >= preset_sat) begin
          out_next = ~OFF_DELAY;
        end
      end
    end
    if (sync_clr) begin
      count_next     = lat_pkg::COUNT_RST;
      out_next       = 1'b0;
      tick_seen_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_reg     <= lat_pkg::COUNT_RST;
      out_reg       <= 1'b0;
      tick_seen_reg <= 1'b0;
    end else begin
      count_reg     <= count_next;
      out_reg       <= out_next;
      tick_seen_reg <= tick_seen_next;
    end
  end
endmodule
`default_nettype wire

// ### design/lat_pkg.sv
// package: constants for the limit alarm and delay timer block
package lat_pkg;
  localparam int unsigned CLK_HZ         = 250000000;
  localparam int unsigned TICK_PERIOD_MS = 10;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_PERIOD_MS;
  localparam int unsigned LIMIT_W        = 16;
  localparam int unsigned PRESET_W       = 14;
  localparam logic [13:0] PRESET_MAX     = 14'h270f;
  localparam logic [13:0] COUNT_RST      = 14'h0000;
  localparam logic [15:0] LIMIT_MAX      = 16'hffff;
  localparam logic [3:0]  ALARM_RST      = 4'h0;
  localparam logic [31:0] TICK_CNT_RST   = 32'h0000_0000;
endpackage

// ### design/lat_top.sv
// module: limit alarm, off/on delay timers and single-scan pulse
// Function
// - while enabled, compare monitored word against four thresholds, drive four alarms
// - thresholds are unsigned 16-bit words, 0 to 65535, from constant or memory
// - upper-upper implies upper; lower-lower implies lower
// - upper alarms on value >= limit; lower alarms on value <= limit
// - alarm enable off drives all four alarms off
// - off-delay output asserts in the same scan its enable goes active
// - off-delay output holds for preset hundredths after enable drops, then clears
// - off-delay re-enable before expiry clears count, output stays on
// - off-delay preset in hundredths, 0 to 9999
// - on-delay output clears in the same scan its enable drops
// - on-delay output asserts after enable held for preset; early drop clears count
// - on-delay preset in hundredths, 0 to 9999
// - single-scan pulse output high for one scan on enable rising edge
`timescale 1ns/10ps
`default_nettype none
module lat_top (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        sync_clr,
  // scan strobe
  input  wire logic        scan_en,
  // limit alarm
  input  wire logic        alarm_enable,
  input  wire logic [15:0] monitored_value,
  input  wire logic [15:0] upper_upper_limit,
  input  wire logic [15:0] upper_limit,
  input  wire logic [15:0] lower_limit,
  input  wire logic [15:0] lower_lower_limit,
  output logic             upper_upper_alarm,
  output logic             upper_alarm,
  output logic             lower_alarm,
  output logic             lower_lower_alarm,
  // off-delay timer
  input  wire logic        off_delay_enable,
  input  wire logic [13:0] off_delay_preset,
  output logic             off_delay_out,
  // on-delay timer
  input  wire logic        on_delay_enable,
  input  wire logic [13:0] on_delay_preset,
  output logic             on_delay_out,
  // single-scan pulse
  input  wire logic        pulse_enable,
  output logic             single_scan_pulse
);
  //////////////////////////////////////////////////////////////////////////////
  // hundredth-second tick
  // restarts only on reset or clear, so a delay may end up to one hundredth early:
  // the tick is not realigned when a timer starts
  // a tick is one cycle wide
  logic [31:0] tick_cnt_reg;
  logic [31:0] tick_cnt_next;
  logic        tick_reg;
  logic        tick_next;

  always_comb begin
    tick_next     = 1'b0;
    tick_cnt_next = tick_cnt_reg + 32'h0000_0001;
    if (tick_cnt_reg == 32'(lat_pkg::TICK_CYCLES - 1)) begin
      tick_cnt_next = lat_pkg::TICK_CNT_RST;
      tick_next     = 1'b1;
    end
    if (sync_clr) begin
      tick_cnt_next = lat_pkg::TICK_CNT_RST;
      tick_next     = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= lat_pkg::TICK_CNT_RST;
      tick_reg     <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // limit alarm, updated once per scan
  typedef struct packed {
    logic upper_upper;
    logic upper;
    logic lower;
    logic lower_lower;
  } lat_alarm_s;

  // one compare serves both directions by swapping the operands
  function automatic logic at_or_above(input logic [15:0] v, input logic [15:0] lim);
    at_or_above = (v >= lim);
  endfunction

  lat_alarm_s alarm_reg;
  lat_alarm_s alarm_next;

  always_comb begin
    alarm_next = alarm_reg;
    if (scan_en) begin
      if (!alarm_enable) begin
        // no power flow: all off whatever the value
        alarm_next = lat_alarm_s'(lat_pkg::ALARM_RST);
      end else begin
        // ordering is not checked, so nesting is forced explicitly
        alarm_next.upper_upper = at_or_above(monitored_value, upper_upper_limit);
        alarm_next.upper       = at_or_above(monitored_value, upper_limit) | alarm_next.upper_upper;
        alarm_next.lower_lower = at_or_above(lower_lower_limit, monitored_value);
        alarm_next.lower       = at_or_above(lower_limit, monitored_value) | alarm_next.lower_lower;
      end
    end
    if (sync_clr) begin
      alarm_next = lat_alarm_s'(lat_pkg::ALARM_RST);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarm_reg <= lat_alarm_s'(lat_pkg::ALARM_RST);
    end else begin
      alarm_reg <= alarm_next;
    end
  end

  assign upper_upper_alarm = alarm_reg.upper_upper;
  assign upper_alarm       = alarm_reg.upper;
  assign lower_alarm       = alarm_reg.lower;
  assign lower_lower_alarm = alarm_reg.lower_lower;

  //////////////////////////////////////////////////////////////////////////////
  // delay timers, each with its own counter
  // both share the one tick but keep their own count and output,
  // so neither sees the other's elapsed time; enables and presets
  // are taken only on scans, one tick in between is remembered
  lat_delay_if off_if ();
  lat_delay_if on_if ();

  assign off_if.enable = off_delay_enable;
  assign off_if.preset = off_delay_preset;
  assign on_if.enable  = on_delay_enable;
  assign on_if.preset  = on_delay_preset;

  lat_delay_timer #(.OFF_DELAY(1'b1)) u_off_delay_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .sync_clr (sync_clr),
    .scan_en  (scan_en),
    .tick     (tick_reg),
    .dly      (off_if.timer)
  );

  lat_delay_timer #(.OFF_DELAY(1'b0)) u_on_delay_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .sync_clr (sync_clr),
    .scan_en  (scan_en),
    .tick     (tick_reg),
    .dly      (on_if.timer)
  );

  assign off_delay_out = off_if.out;
  assign on_delay_out  = on_if.out;

  //////////////////////////////////////////////////////////////////////////////
  // single-scan pulse (rising edge coil)
  // power flow seen at the last scan; clear counts as off, so flow already
  // high at the first scan after reset gives one pulse
  typedef enum logic {
    LAT_FLOW_OFF,
    LAT_FLOW_ON
  } lat_flow_e;

  lat_flow_e prev_flow_reg;
  lat_flow_e prev_flow_next;
  logic      pulse_reg;
  logic      pulse_next;

  always_comb begin
    prev_flow_next = prev_flow_reg;
    pulse_next     = pulse_reg;
    if (scan_en) begin
      pulse_next = 1'b0;
      case (prev_flow_reg)
        LAT_FLOW_OFF: begin
          if (pulse_enable) begin
            prev_flow_next = LAT_FLOW_ON;
            pulse_next     = 1'b1;
          end
        end
        LAT_FLOW_ON: begin
          if (!pulse_enable) begin
            prev_flow_next = LAT_FLOW_OFF;
          end
        end
        default: begin
          // unreachable; fall back to off so a bad state cannot pulse
          prev_flow_next = LAT_FLOW_OFF;
        end
      endcase
    end
    if (sync_clr) begin
      prev_flow_next = LAT_FLOW_OFF;
      pulse_next     = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_flow_reg <= LAT_FLOW_OFF;
      pulse_reg     <= 1'b0;
    end else begin
      prev_flow_reg <= prev_flow_next;
      pulse_reg     <= pulse_next;
    end
  end

  assign single_scan_pulse = pulse_reg;
endmodule
`default_nettype wire

// ### verif/lat_scan_src.sv
// model: surrounding scan logic issuing scan strobes
`timescale 1ns/10ps
`default_nettype none
module lat_scan_src (
  // clock and control
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic run,
  // scan strobe
  output var logic  scan_en
);
  // moves on the falling edge so the block samples it settled; lags run by one cycle
  always @(negedge core_clk or posedge rst) begin
    if (rst) begin
      scan_en <= 1'b0;
    end else begin
      scan_en <= run;
    end
  end
endmodule
`default_nettype wire

// ### verif/lat_top_bench.sv
// testbench: alarm table, timers, pulse and clear of lat_top
`timescale 1ns/10ps
`default_nettype none
module lat_top_bench;
  typedef struct packed { logic ae; logic [15:0] mv; logic [3:0] al; } lat_row_s;
  logic        core_clk = 1'b0, rst = 1'b1, sync_clr = 1'b0, run = 1'b0, scan_en;
  logic        alarm_enable = 1'b0, off_delay_enable = 1'b0, on_delay_enable = 1'b0, pulse_enable = 1'b0;
  logic [15:0] monitored_value = 16'h0000, upper_upper_limit = 16'h03e8, upper_limit = 16'h0384;
  logic [15:0] lower_limit = 16'h00c8, lower_lower_limit = 16'h0064; // kept ordered
  logic [13:0] off_delay_preset = 14'h0000, on_delay_preset = 14'h0000;
  logic        upper_upper_alarm, upper_alarm, lower_alarm, lower_lower_alarm;
  logic        off_delay_out, on_delay_out, single_scan_pulse;
  int          fail_count = 0, samples_checked = 0;
  wire logic [6:0] outs = {upper_upper_alarm, upper_alarm, lower_alarm, lower_lower_alarm,
                           off_delay_out, on_delay_out, single_scan_pulse};
  lat_row_s rows [12] = '{'{1'b1, 16'h03e8, 4'hc}, '{1'b1, 16'h03e7, 4'h4}, '{1'b1, 16'h0384, 4'h4},
    '{1'b1, 16'h0383, 4'h0}, '{1'b1, 16'h00c9, 4'h0}, '{1'b1, 16'h00c8, 4'h2}, '{1'b1, 16'h0065, 4'h2},
    '{1'b1, 16'h0064, 4'h3}, '{1'b1, 16'h0000, 4'h3}, '{1'b1, 16'hffff, 4'hc}, '{1'b0, 16'hffff, 4'h0},
    '{1'b0, 16'h0000, 4'h0}};
  // each timer instance inside holds its own counter
  lat_top dut (.*);
  lat_scan_src src (.core_clk(core_clk), .rst(rst), .run(run), .scan_en(scan_en));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(input string what, input logic [6:0] exp);
    samples_checked++;
    if (outs !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, outs);
    end
  endtask
  task automatic end_sim();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #4000;
    fail_count++;
    end_sim();
  end
  initial begin
    cyc(4);
    rst <= 1'b0;
    run <= 1'b1;
    chk("reset", 7'h00);
    cyc(1);
    foreach (rows[i]) begin
      alarm_enable <= rows[i].ae;
      monitored_value <= rows[i].mv;
      cyc(1);
      chk("alarm row", {rows[i].al, 3'h0});
    end
    // extreme limits: both upper limits at the top, both lower limits at zero
    {upper_upper_limit, upper_limit, lower_limit, lower_lower_limit} <= {16'hffff, 16'hffff, 16'h0000, 16'h0000};
    alarm_enable <= 1'b1;
    monitored_value <= 16'hffff;
    cyc(1);
    chk("top limit", 7'h60);
    monitored_value <= 16'h0000;
    cyc(1);
    chk("zero limit", 7'h18);
    alarm_enable <= 1'b0;
    off_delay_preset <= 14'h0005;
    off_delay_enable <= 1'b1;
    cyc(1);
    chk("off rise", 7'h04);
    off_delay_enable <= 1'b0;
    cyc(20);
    chk("off hold", 7'h04);
    off_delay_enable <= 1'b1;
    cyc(1);
    off_delay_enable <= 1'b0;
    cyc(1);
    chk("off retrigger", 7'h04);
    off_delay_preset <= 14'h0000;
    cyc(1);
    chk("off expire", 7'h00);
    on_delay_preset <= 14'h0005;
    on_delay_enable <= 1'b1;
    cyc(20);
    chk("on wait", 7'h00);
    on_delay_preset <= 14'h0000;
    cyc(1);
    chk("on zero", 7'h02);
    on_delay_enable <= 1'b0;
    cyc(1);
    chk("on drop", 7'h00);
    pulse_enable <= 1'b1;
    cyc(1);
    chk("pulse", 7'h01);
    cyc(1);
    chk("pulse once", 7'h00);
    pulse_enable <= 1'b0;
    run <= 1'b0;
    cyc(1);
    pulse_enable <= 1'b1;
    cyc(3);
    chk("no scan", 7'h00);
    run <= 1'b1;
    cyc(2);
    chk("late pulse", 7'h01);
    alarm_enable <= 1'b1;
    off_delay_enable <= 1'b1;
    cyc(1);
    chk("pre clear", 7'h1c);
    rst <= 1'b1;
    cyc(1);
    chk("mid reset", 7'h00);
    rst <= 1'b0;
    cyc(2);
    chk("after reset", 7'h1d);
    sync_clr <= 1'b1;
    cyc(1);
    chk("clear", 7'h00);
    end_sim();
  end
endmodule
`default_nettype wire

// ### verif/lat_top_sva.sv
// checker: port-level properties of lat_top
`timescale 1ns/10ps
`default_nettype none
module lat_chk (
  // clock and strobes
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        sync_clr,
  input wire logic        scan_en,
  // alarm
  input wire logic        alarm_enable,
  input wire logic [15:0] monitored_value,
  input wire logic [15:0] upper_upper_limit,
  input wire logic [15:0] upper_limit,
  input wire logic [15:0] lower_limit,
  input wire logic [15:0] lower_lower_limit,
  input wire logic        upper_upper_alarm,
  input wire logic        upper_alarm,
  input wire logic        lower_alarm,
  input wire logic        lower_lower_alarm,
  // timers and pulse
  input wire logic        off_delay_enable,
  input wire logic        off_delay_out,
  input wire logic        on_delay_enable,
  input wire logic        on_delay_out,
  input wire logic        pulse_enable,
  input wire logic        single_scan_pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [15:0] mv;
  logic        sc;
  logic        pe_seen;
  logic [3:0]  hit;
  logic [6:0]  outs;
  assign mv   = monitored_value;
  assign sc   = scan_en && !sync_clr;
  assign hit  = {mv >= upper_upper_limit, mv >= upper_limit || mv >= upper_upper_limit,
                 mv <= lower_limit || mv <= lower_lower_limit, mv <= lower_lower_limit};
  assign outs = {upper_upper_alarm, upper_alarm, lower_alarm, lower_lower_alarm,
                 off_delay_out, on_delay_out, single_scan_pulse};
  // own copy of the last scanned pulse enable, so the edge check does not lean on the design
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pe_seen <= 1'b0;
    end else if (sync_clr) begin
      pe_seen <= 1'b0;
    end else if (scan_en) begin
      pe_seen <= pulse_enable;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_alarm_level: assert property (sc && alarm_enable |=> outs[6:3] == $past(hit))
    else $error("alarm levels wrong");
  a_alarm_off: assert property (scan_en && !alarm_enable |=> outs[6:3] == 4'h0)
    else $error("alarm on while disabled");
  a_nest_upper: assert property (upper_upper_alarm |-> upper_alarm)
    else $error("upper-upper without upper");
  a_nest_lower: assert property (lower_lower_alarm |-> lower_alarm)
    else $error("lower-lower without lower");
  a_off_now: assert property (sc && off_delay_enable |=> off_delay_out)
    else $error("off-delay output late");
  a_on_drop: assert property (scan_en && !on_delay_enable |=> !on_delay_out)
    else $error("on-delay output kept");
  a_pulse_edge: assert property (sc |=> single_scan_pulse == ($past(pulse_enable) && !$past(pe_seen)))
    else $error("pulse wrong");
  a_hold_between: assert property (!scan_en && !sync_clr |=> $stable(outs))
    else $error("output moved between scans");
  a_clear_all: assert property (sync_clr |=> outs == 7'h00)
    else $error("clear left output on");
  c_top_alarm: cover property (upper_upper_alarm);
  c_pulse: cover property (single_scan_pulse);
  c_off_hold: cover property (off_delay_out && !off_delay_enable);
endmodule
bind lat_top lat_chk u_chk (.*);
`default_nettype wire
